// *** bench/eeprom_flash_access_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module eeprom_flash_access_ctrl_tb;
  localparam logic [7:0] ALO = nv_access_pkg::ADDR_LOW_OFF;
  localparam logic [7:0] AHI = nv_access_pkg::ADDR_HIGH_OFF;
  localparam logic [7:0] DLO = nv_access_pkg::DATA_LOW_OFF;
  localparam logic [7:0] DHI = nv_access_pkg::DATA_HIGH_OFF;
  localparam logic [7:0] CTL = nv_access_pkg::CONTROL_OFF;
  localparam logic [7:0] UNL = nv_access_pkg::UNLOCK_OFF;
  localparam logic [7:0] STS = nv_access_pkg::STATUS_OFF;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        warm_reset, prog_rd_en, write_done_flag;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] prog_addr;
  logic [13:0] prog_rdata;
  int          fails = 0;
  int          n_tests = 0;
  nv_access_ctrl #(.WRITE_CYCLES(8)) nv_access_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .warm_reset(warm_reset),
    .prog_addr(prog_addr), .prog_rd_en(prog_rd_en), .prog_rdata(prog_rdata),
    .write_done_flag(write_done_flag));
  nv_prog_mem_model nv_prog_mem_model_inst (
    .pclk(pclk), .prog_addr(prog_addr), .prog_rd_en(prog_rd_en), .prog_rdata(prog_rdata));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  task automatic start_write(input logic [7:0] a, input logic [7:0] d);
    w(ALO, {24'h0, a});
    w(DLO, {24'h0, d});
    w(CTL, 32'h04);
    w(UNL, 32'h55);
    w(UNL, 32'hAA);
    w(CTL, 32'h06);
  endtask
  task automatic wait_idle();
    do apb(1'b0, CTL, 32'h0); while (rd[1] !== 1'b0);
  endtask
  task automatic read_byte(input logic [7:0] a, input logic [7:0] e);
    w(ALO, {24'h0, a});
    w(DLO, 32'h0);
    w(CTL, 32'h01);
    rdc(DLO, {24'h0, e}, "data_byte");
  endtask
  task automatic try_bad(input logic [7:0] a1, d1, a2, d2, a3, d3);
    w(CTL, 32'h04);
    w(a1, {24'h0, d1});
    w(a2, {24'h0, d2});
    w(a3, {24'h0, d3});
    w(CTL, 32'h06);
    apb(1'b0, CTL, 32'h0);
    `CHK("wr_refused", 1'b0, rd[1])
    repeat (12) @(posedge pclk);
    `CHK("no_done", 1'b0, write_done_flag)
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, warm_reset} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CTL, 32'h0, "ctl_reset");
    rdc(UNL, 32'h0, "unlock_read");
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("slverr", 1'b1, err)
    start_write(8'h3C, 8'hA5);
    rdc(CTL, 32'h06, "wr_busy");
    w(CTL, 32'h00);
    wait_idle();
    `CHK("done_set", 1'b1, write_done_flag)
    w(STS, 32'h1);
    @(posedge pclk);
    `CHK("done_kept", 1'b1, write_done_flag)
    w(STS, 32'h0);
    @(posedge pclk);
    `CHK("done_clr", 1'b0, write_done_flag)
    read_byte(8'h3C, 8'hA5);
    rdc(DLO, 32'hA5, "data_hold");
    rdc(CTL, 32'h0, "rd_clear");
    try_bad(UNL, 8'hAA, UNL, 8'h55, DLO, 8'h5A);
    try_bad(UNL, 8'h55, UNL, 8'hAA, ALO, 8'h3D);
    try_bad(UNL, 8'h55, UNL, 8'hAA, CTL, 8'h02);
    start_write(8'h3D, 8'h5A);
    wait_idle();
    rdc(CTL, 32'h04, "write_enable_bit_kept");
    read_byte(8'h3D, 8'h5A);
    w(STS, 32'h0);
    start_write(8'h50, 8'h11);
    warm_reset <= 1'b1;
    @(posedge pclk);
    warm_reset <= 1'b0;
    apb(1'b0, CTL, 32'h0);
    `CHK("err_bit", 1'b1, rd[3])
    rdc(ALO, 32'h50, "addr_kept");
    rdc(DLO, 32'h11, "data_kept");
    `CHK("no_done_abort", 1'b0, write_done_flag)
    w(ALO, 32'h34);
    w(AHI, 32'h12);
    w(CTL, 32'h81);
    rdc(DLO, 32'h6E, "prog_low");
    rdc(DHI, 32'h38, "prog_high");
    apb(1'b0, CTL, 32'h0);
    `CHK("prog_rd_clr", 8'h80, rd[7:0] & 8'h81)
    close_out();
  end
endmodule // eeprom_flash_access_ctrl_tb
`undef CHK
`default_nettype wire

// *** bench/nv_access_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module nv_access_ctrl_asserts #(
  parameter int WRITE_CYCLES = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        warm_reset,
  input wire logic [12:0] prog_addr,
  input wire logic        prog_rd_en,
  input wire logic [13:0] prog_rdata,
  input wire logic        write_done_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic take;
  assign take = psel && penable && pready;
  ready_one_cycle_a: assert property (pready |=> !pready) else $error("pready stood two cycles");
  slverr_quiet_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
  unmapped_err_a: assert property (take && paddr > nv_access_pkg::STATUS_OFF |-> pslverr)
    else $error("unmapped access not refused");
  unlock_zero_a: assert property (take && !pwrite && paddr == nv_access_pkg::UNLOCK_OFF |-> prdata == 32'h0)
    else $error("unlock register read nonzero");
  fetch_two_a: assert property ($rose(prog_rd_en) |-> prog_rd_en [*2] ##1 !prog_rd_en)
    else $error("program fetch not two cycles");
  fetch_cause_a: assert property ($rose(prog_rd_en) |->
    $past(take && pwrite && paddr == nv_access_pkg::CONTROL_OFF && pwdata[7] && pwdata[0]))
    else $error("program fetch without start");
  fetch_addr_a: assert property (prog_rd_en && $past(prog_rd_en) |-> $stable(prog_addr))
    else $error("fetch address moved");
  fetch_hold_a: assert property (prog_rd_en |-> !pready)
    else $error("bus answered during program fetch");
  done_hold_a: assert property ($fell(write_done_flag) |->
    $past(take && pwrite && paddr == nv_access_pkg::STATUS_OFF && !pwdata[0]))
    else $error("done flag cleared by hardware");
  cover property ($rose(write_done_flag));
  cover property ($rose(prog_rd_en));
  cover property (take && pslverr);
endmodule // nv_access_ctrl_asserts
bind nv_access_ctrl nv_access_ctrl_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) nv_access_ctrl_asserts_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .warm_reset(warm_reset),
  .prog_addr(prog_addr), .prog_rd_en(prog_rd_en), .prog_rdata(prog_rdata), .write_done_flag(write_done_flag));
`default_nettype wire

// *** bench/nv_prog_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module nv_prog_mem_model (
  input  wire logic        pclk,
  input  wire logic [12:0] prog_addr,
  input  wire logic        prog_rd_en,
  output logic      [13:0] prog_rdata
);
  logic [13:0] last = 14'h0000;
  always @(posedge pclk) begin
    if (prog_rd_en) begin
      last <= {1'b1, prog_addr ^ 13'h0A5A};
    end
  end
  // word is a fixed scramble of the address; idle shows the inverse of the last word
  assign prog_rdata = prog_rd_en ? {1'b1, prog_addr ^ 13'h0A5A} : ~last;
endmodule // nv_prog_mem_model
`default_nettype wire

// *** core/nv_access_ctrl.sv ***
// Notes on behaviour
// - data byte appears on next cycle
// - low data holds until read or write
// - write needs 55h, AAh, then write-start
// - write-start ignored without write enable
// - hardware clears write enable only on warm reset
// - clearing enable does not abort write
// - completion clears write-start, sets done flag
// - done flag stays until software clears
// - program read fetches for two cycles
// - program word lands in both data registers
// - read-start software set, hardware cleared
// - warm reset mid-write sets error flag
// - unlock register reads as zero
`timescale 1ns/1ps
`default_nettype none
module nv_access_ctrl #(
  parameter int WRITE_CYCLES = nv_access_pkg::WRITE_CYCLES
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic [7:0]                          paddr,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic                                warm_reset,
  output logic      [nv_access_pkg::PROG_ADDR_W-1:0] prog_addr,
  output logic                                     prog_rd_en,
  input  wire logic [nv_access_pkg::PROG_WORD_W-1:0] prog_rdata,
  output logic                                     write_done_flag
);

  typedef struct packed {
    logic                                   pready;
    logic [31:0]                            prdata;
    logic                                   pslverr;
    logic [nv_access_pkg::ADDR_LOW_W-1:0]   addr_low;
    logic [nv_access_pkg::ADDR_HIGH_W-1:0]  addr_high;
    logic [nv_access_pkg::DATA_LOW_W-1:0]   data_low;
    logic [nv_access_pkg::DATA_HIGH_W-1:0]  data_high;
    logic                                   prog_data_select;
    logic                                   write_error_flag;
    logic                                   write_enable_bit;
    logic                                   wr;
    logic                                   rd;
    logic                                   write_done_flag;
    nv_access_pkg::unlock_e                 unlock;
    logic [1:0]                             fetch_cnt;
    logic [nv_access_pkg::PROG_ADDR_W-1:0]  prog_addr;
    logic                                   prog_rd_en;
    logic                                   wr_start;
  } ctrl_s;

  ctrl_s st;
  ctrl_s next_st;

  logic [nv_access_pkg::DATA_LOW_W-1:0] ee_rd_data;
  logic                                 arr_busy;
  logic                                 arr_done;
  logic                                 take;
  logic                                 take_wr;
  logic                                 write_busy;
  logic                                 new_select;
  logic                                 new_enable;
  logic [31:0]                          rd_word;
  logic                                 rd_hit;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == nv_access_pkg::ADDR_LOW_OFF)  || (a == nv_access_pkg::ADDR_HIGH_OFF) ||
             (a == nv_access_pkg::DATA_LOW_OFF)  || (a == nv_access_pkg::DATA_HIGH_OFF) ||
             (a == nv_access_pkg::CONTROL_OFF)   || (a == nv_access_pkg::UNLOCK_OFF)    ||
             (a == nv_access_pkg::STATUS_OFF);
  endfunction

  function automatic logic [31:0] control_word(input ctrl_s s);
    control_word = 32'h0000_0000;
    control_word[nv_access_pkg::SELECT_BIT] = s.prog_data_select;
    control_word[nv_access_pkg::ERROR_BIT]  = s.write_error_flag;
    control_word[nv_access_pkg::WRITE_ENABLE_BIT_BIT]   = s.write_enable_bit;
    control_word[nv_access_pkg::WR_BIT]     = s.wr;
    control_word[nv_access_pkg::RD_BIT]     = s.rd;
  endfunction

  nv_data_array #(
    .ADDR_W       (nv_access_pkg::ADDR_LOW_W),
    .DATA_W       (nv_access_pkg::DATA_LOW_W),
    .WRITE_CYCLES (WRITE_CYCLES)
  ) nv_data_array_inst (
    .pclk     (pclk),
    .presetn  (presetn),
    .rd_addr  (st.addr_low),
    .rd_data  (ee_rd_data),
    .wr_start (st.wr_start),
    .wr_addr  (st.addr_low),
    .wr_data  (st.data_low),
    .abort    (warm_reset),
    .busy     (arr_busy),
    .done     (arr_done)
  );

  assign take       = psel && penable && st.pready;
  assign take_wr    = take && pwrite && !st.pslverr;
  assign write_busy = st.wr || st.wr_start || arr_busy;
  assign new_select = write_busy ? st.prog_data_select : pwdata[nv_access_pkg::SELECT_BIT];
  assign new_enable = pwdata[nv_access_pkg::WRITE_ENABLE_BIT_BIT];

  // read mux; unlock reads all zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (paddr)
      nv_access_pkg::ADDR_LOW_OFF:  rd_word[nv_access_pkg::ADDR_LOW_W-1:0]  = st.addr_low;
      nv_access_pkg::ADDR_HIGH_OFF: rd_word[nv_access_pkg::ADDR_HIGH_W-1:0] = st.addr_high;
      nv_access_pkg::DATA_LOW_OFF:  rd_word[nv_access_pkg::DATA_LOW_W-1:0]  = st.data_low;
      nv_access_pkg::DATA_HIGH_OFF: rd_word[nv_access_pkg::DATA_HIGH_W-1:0] = st.data_high;
      nv_access_pkg::CONTROL_OFF:   rd_word = control_word(st);
      nv_access_pkg::UNLOCK_OFF:    rd_word = 32'h0000_0000;
      nv_access_pkg::STATUS_OFF:    rd_word[nv_access_pkg::DONE_BIT] = st.write_done_flag;
      default:                      rd_hit  = 1'b0;
    endcase
  end

  always_comb begin
    next_st          = st;
    next_st.wr_start = 1'b0;

    // apb: one wait state, held off while a program fetch runs
    next_st.pready = psel && penable && !st.pready && (st.fetch_cnt == 2'h0);
    if (psel && penable && !st.pready) begin
      next_st.pslverr = !mapped(paddr);
      next_st.prdata  = (!pwrite && rd_hit) ? rd_word : 32'h0000_0000;
    end else if (take) begin
      next_st.pslverr = 1'b0;
    end

    if (take_wr) begin
      // any accepted write to another register breaks the unlock
      if (paddr != nv_access_pkg::UNLOCK_OFF) begin
        next_st.unlock = nv_access_pkg::UNLOCK_IDLE;
      end
      unique case (paddr)
        nv_access_pkg::ADDR_LOW_OFF: begin
          next_st.addr_low = pwdata[nv_access_pkg::ADDR_LOW_W-1:0];
        end
        nv_access_pkg::ADDR_HIGH_OFF: begin
          next_st.addr_high = pwdata[nv_access_pkg::ADDR_HIGH_W-1:0];
        end
        nv_access_pkg::DATA_LOW_OFF: begin
          next_st.data_low = pwdata[nv_access_pkg::DATA_LOW_W-1:0];
        end
        nv_access_pkg::DATA_HIGH_OFF: begin
          next_st.data_high = pwdata[nv_access_pkg::DATA_HIGH_W-1:0];
        end
        nv_access_pkg::CONTROL_OFF: begin
          next_st.prog_data_select = new_select;
          next_st.write_error_flag = pwdata[nv_access_pkg::ERROR_BIT];
          next_st.write_enable_bit = new_enable;
          // read start; only software sets it
          if (pwdata[nv_access_pkg::RD_BIT] && !st.rd) begin
            if (new_select) begin
              next_st.rd         = 1'b1;
              next_st.fetch_cnt  = nv_access_pkg::PROG_FETCH_CYCLES;
              next_st.prog_addr  = {st.addr_high, st.addr_low};
              next_st.prog_rd_en = 1'b1;
            end else begin
              next_st.data_low = ee_rd_data;
            end
          end
          // write start needs the full unlock and write enable
          if (pwdata[nv_access_pkg::WR_BIT] && !write_busy && !new_select &&
              new_enable && st.write_enable_bit &&
              st.unlock == nv_access_pkg::UNLOCK_ARMED) begin
            next_st.wr       = 1'b1;
            next_st.wr_start = 1'b1;
          end
        end
        nv_access_pkg::UNLOCK_OFF: begin
          unique case (st.unlock)
            nv_access_pkg::UNLOCK_IDLE: begin
              if (pwdata[7:0] == nv_access_pkg::UNLOCK_KEY_FIRST) begin
                next_st.unlock = nv_access_pkg::UNLOCK_GOT_FIRST;
              end
            end
            nv_access_pkg::UNLOCK_GOT_FIRST: begin
              if (pwdata[7:0] == nv_access_pkg::UNLOCK_KEY_SECOND) begin
                next_st.unlock = nv_access_pkg::UNLOCK_ARMED;
              end else if (pwdata[7:0] == nv_access_pkg::UNLOCK_KEY_FIRST) begin
                next_st.unlock = nv_access_pkg::UNLOCK_GOT_FIRST;
              end else begin
                next_st.unlock = nv_access_pkg::UNLOCK_IDLE;
              end
            end
            nv_access_pkg::UNLOCK_ARMED: begin
              // a third key write spoils the order
              next_st.unlock = (pwdata[7:0] == nv_access_pkg::UNLOCK_KEY_FIRST) ?
                               nv_access_pkg::UNLOCK_GOT_FIRST : nv_access_pkg::UNLOCK_IDLE;
            end
            default: begin
              next_st.unlock = nv_access_pkg::UNLOCK_IDLE;
            end
          endcase
        end
        nv_access_pkg::STATUS_OFF: begin
          // writing zero clears, writing one leaves it
          if (!pwdata[nv_access_pkg::DONE_BIT]) begin
            next_st.write_done_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // program fetch runs two cycles, then both data bytes load
    if (st.fetch_cnt != 2'h0) begin
      next_st.fetch_cnt = st.fetch_cnt - 2'h1;
      if (st.fetch_cnt == 2'h1) begin
        next_st.data_low   = prog_rdata[nv_access_pkg::DATA_LOW_W-1:0];
        next_st.data_high  = prog_rdata[nv_access_pkg::PROG_WORD_W-1:nv_access_pkg::DATA_LOW_W];
        next_st.rd         = 1'b0;
        next_st.prog_rd_en = 1'b0;
      end
    end

    // completion wins over a software clear in the same cycle
    if (arr_done) begin
      next_st.wr              = 1'b0;
      next_st.write_done_flag = 1'b1;
    end

    // warm reset: abort, flag error if a write is busy, keep address and data
    if (warm_reset) begin
      if (write_busy) begin
        next_st.write_error_flag = 1'b1;
      end
      next_st.prog_data_select = 1'b0;
      next_st.write_enable_bit = 1'b0;
      next_st.wr               = 1'b0;
      next_st.wr_start         = 1'b0;
      next_st.rd               = 1'b0;
      next_st.fetch_cnt        = 2'h0;
      next_st.prog_rd_en       = 1'b0;
      next_st.unlock           = nv_access_pkg::UNLOCK_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.pready           <= 1'b0;
      st.prdata           <= nv_access_pkg::PRDATA_RST;
      st.pslverr          <= 1'b0;
      st.addr_low         <= nv_access_pkg::ADDR_LOW_RST;
      st.addr_high        <= nv_access_pkg::ADDR_HIGH_RST;
      st.data_low         <= nv_access_pkg::DATA_LOW_RST;
      st.data_high        <= nv_access_pkg::DATA_HIGH_RST;
      st.prog_data_select <= 1'b0;
      st.write_error_flag <= 1'b0;
      st.write_enable_bit <= 1'b0;
      st.wr               <= 1'b0;
      st.rd               <= 1'b0;
      st.write_done_flag  <= 1'b0;
      st.unlock           <= nv_access_pkg::UNLOCK_IDLE;
      st.fetch_cnt        <= 2'h0;
      st.prog_addr        <= '0;
      st.prog_rd_en       <= 1'b0;
      st.wr_start         <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata          = st.prdata;
  assign pready          = st.pready;
  assign pslverr         = st.pslverr;
  assign prog_addr       = st.prog_addr;
  assign prog_rd_en      = st.prog_rd_en;
  assign write_done_flag = st.write_done_flag;

endmodule // nv_access_ctrl
`default_nettype wire

// *** core/nv_access_pkg.sv ***
`default_nettype none
package nv_access_pkg;

  // apb register map, byte addresses
  localparam logic [7:0] ADDR_LOW_OFF  = 8'h00;
  localparam logic [7:0] ADDR_HIGH_OFF = 8'h04;
  localparam logic [7:0] DATA_LOW_OFF  = 8'h08;
  localparam logic [7:0] DATA_HIGH_OFF = 8'h0C;
  localparam logic [7:0] CONTROL_OFF   = 8'h10;
  localparam logic [7:0] UNLOCK_OFF    = 8'h14;
  localparam logic [7:0] STATUS_OFF    = 8'h18;

  // control register fields
  localparam int SELECT_BIT = 7;
  localparam int ERROR_BIT  = 3;
  localparam int WRITE_ENABLE_BIT_BIT   = 2;
  localparam int WR_BIT     = 1;
  localparam int RD_BIT     = 0;
  // status register fields
  localparam int DONE_BIT   = 0;

  // field widths
  localparam int ADDR_LOW_W  = 8;
  localparam int ADDR_HIGH_W = 5;
  localparam int DATA_LOW_W  = 8;
  localparam int DATA_HIGH_W = 6;
  localparam int PROG_ADDR_W = ADDR_HIGH_W + ADDR_LOW_W;
  localparam int PROG_WORD_W = DATA_HIGH_W + DATA_LOW_W;

  // unlock keys
  localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

  // reset values
  localparam logic [7:0]  ADDR_LOW_RST  = 8'h00;
  localparam logic [4:0]  ADDR_HIGH_RST = 5'h00;
  localparam logic [7:0]  DATA_LOW_RST  = 8'h00;
  localparam logic [5:0]  DATA_HIGH_RST = 6'h00;
  localparam logic [31:0] PRDATA_RST    = 32'h0000_0000;

  // timing
  localparam int          CLK_PERIOD_NS     = 20;
  localparam int          WRITE_TIME_US     = 4000;
  localparam int          WRITE_CYCLES      = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam logic [1:0]  PROG_FETCH_CYCLES = 2'h2;

  typedef enum logic [2:0] {
    UNLOCK_IDLE      = 3'h1,
    UNLOCK_GOT_FIRST = 3'h2,
    UNLOCK_ARMED     = 3'h4
  } unlock_e;

endpackage
`default_nettype wire

// *** core/nv_data_array.sv ***
`timescale 1ns/1ps
`default_nettype none
module nv_data_array #(
  parameter int ADDR_W       = 8,
  parameter int DATA_W       = 8,
  parameter int WRITE_CYCLES = 200000
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              wr_start,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              abort,
  output logic                   busy,
  output logic                   done
);

  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST_COUNT = CNT_W'(WRITE_CYCLES - 1);

  typedef struct packed {
    logic              busy;
    logic              done;
    logic [CNT_W-1:0]  cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } array_s;

  array_s st;
  array_s next_st;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic commit;

  assign rd_data = mem[rd_addr];
  assign busy    = st.busy;
  assign done    = st.done;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    commit       = 1'b0;
    if (st.busy) begin
      // an abort drops the cell untouched
      if (abort) begin
        next_st.busy = 1'b0;
      end else if (st.cnt == LAST_COUNT) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        commit       = 1'b1;
      end else begin
        next_st.cnt = st.cnt + CNT_W'(1);
      end
    end else if (wr_start && !abort) begin
      next_st.busy = 1'b1;
      next_st.cnt  = '0;
      next_st.addr = wr_addr;
      next_st.data = wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // cell contents survive every reset
  always_ff @(posedge pclk) begin
    if (commit) begin
      mem[st.addr] <= st.data;
    end
  end

endmodule // nv_data_array
`default_nettype wire
